// ---- hw/cmc_top.sv ----
// Purpose: operating mode control and top-level control/status
//   registers of a CAN controller, reached over APB
// Assumes: single clock pclk at 100 MHz; protocol engine outside
// Notes: registers answer with one wait state
`timescale 1ns/1ps
`include "cmc_map.svh"

module cmc_top
  import cmc_pkg::*;
#(
  parameter int BIT_CYC = `CMC_BIT_CYC,
  parameter int WAKE_CYC = `CMC_WAKE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_receive_line,
  output logic bus_transmit_line,
  output logic bus_transmit_oe_n,
  output logic bus_pins_owned,
  input wire logic dev_idle,
  input wire logic dev_sleep,
  input wire logic eng_tx_bit,
  input wire logic eng_tx_busy,
  input wire logic [7:0] eng_tx_done,
  input wire logic eng_rx_msg,
  input wire logic eng_vec_we,
  input wire logic [4:0] eng_filter_hit,
  input wire logic [6:0] eng_interrupt_code,
  input wire logic [5:0] eng_fifo_wr,
  input wire logic [5:0] eng_fifo_rd,
  output logic eng_rx_bit,
  output logic eng_enable,
  output logic [7:0] tx_go,
  output logic tx_abort,
  output logic err_ignore,
  output logic listen_passive,
  output logic err_cnt_clear,
  output logic err_cnt_hold,
  output logic cap_event,
  output logic wake_filter_on,
  output logic filter_window,
  output logic [4:0] net_filter_bits,
  output logic [5:0] dma_buf_total,
  output logic [4:0] fifo_start
);

  // register state
  logic stop_in_idle_r;
  logic abort_all_tx_r;
  logic [2:0] mode_request_r;
  cmc_mode_t mode_status_r;
  logic rx_capture_link_en_r;
  logic register_window_select_r;
  logic [4:0] net_filter_bit_count_r;
  logic [4:0] filter_hit_number_r;
  logic [6:0] interrupt_code_r;
  logic [2:0] dma_buffer_count_r;
  logic [4:0] fifo_start_buffer_r;
  logic [5:0] fifo_write_pointer_r;
  logic [5:0] fifo_next_read_pointer_r;
  logic [7:0] tx_request_flag_r;
  logic [7:0] tx_aborted_flag_r;
  logic bus_wake_flag_r;
  logic wake_filter_select_r;
  logic tx_wait_r;
  logic wake_lo_r;
  logic [7:0] wcnt_r;

  // apb decode
  wire setup_acc = psel & penable & ~pready;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire hit_c1 = (paddr == `CMC_OFS_CTRL1);
  wire hit_c2 = (paddr == `CMC_OFS_CTRL2);
  wire hit_vec = (paddr == `CMC_OFS_VEC);
  wire hit_fc = (paddr == `CMC_OFS_FCTRL);
  wire hit_fp = (paddr == `CMC_OFS_FPTR);
  wire hit_txc = (paddr == `CMC_OFS_TXC);
  wire hit_any = hit_c1 | hit_c2 | hit_vec | hit_fc | hit_fp | hit_txc;
  wire is_cfg = (mode_status_r == CMC_CONFIG);
  wire wr_c1 = wr & hit_c1;
  wire wr_c2 = wr & hit_c2 & is_cfg;
  wire wr_fc = wr & hit_fc & is_cfg;
  wire wr_txc = wr & hit_txc;

  // read words
  wire [31:0] rd_c1 = {16'h0000, 2'b00, stop_in_idle_r, abort_all_tx_r,
    1'b0, mode_request_r, mode_status_r, 1'b0, rx_capture_link_en_r,
    2'b00, register_window_select_r};
  wire [31:0] rd_c2 = {27'h0, net_filter_bit_count_r};
  wire [31:0] rd_vec = {19'h0, filter_hit_number_r, 1'b0,
    interrupt_code_r};
  wire [31:0] rd_fc = {16'h0000, dma_buffer_count_r, 8'h00,
    fifo_start_buffer_r};
  wire [31:0] rd_fp = {18'h0, fifo_write_pointer_r, 2'b00,
    fifo_next_read_pointer_r};
  wire [31:0] rd_txc = {14'h0, wake_filter_select_r, bus_wake_flag_r,
    tx_aborted_flag_r, tx_request_flag_r};
  wire [31:0] rd_mux = hit_c1 ? rd_c1 :
                       hit_c2 ? rd_c2 :
                       hit_vec ? rd_vec :
                       hit_fc ? rd_fc :
                       hit_fp ? rd_fp :
                       hit_txc ? rd_txc : 32'h0000_0000;

  // pin input and bus idle
  logic rx_s;
  logic idle_ok;
  wire is_loop = (mode_status_r == CMC_LOOPBACK);
  wire idle_rx = is_loop ? eng_tx_bit : rx_s;

  cmc_sync #(
    .RST_VAL(1'b1)
  ) u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(bus_receive_line),
    .q(rx_s)
  );

  // mode acceptance
  wire [2:0] wreq = pwdata[`CMC_F_REQ +: 3];
  wire req_legal = (mode_request_r != CMC_RSVD5) &&
                   (mode_request_r != CMC_RSVD6);
  wire offline = is_cfg || (mode_status_r == CMC_DISABLE);
  // an active controller only moves at bus idle and never mid-frame
  wire change_ok = req_legal && (mode_request_r != mode_status_r) &&
                   (offline || (idle_ok && !eng_tx_busy));

  cmc_bus_idle #(
    .BIT_CYC(BIT_CYC)
  ) u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .restart(change_ok),
    .rx(idle_rx),
    .idle_ok(idle_ok)
  );

  wire [2:0] new_mode = mode_request_r;
  wire new_tx_mode = (new_mode == CMC_NORMAL) ||
                     (new_mode == CMC_LOOPBACK);
  wire st_normal = (mode_status_r == CMC_NORMAL);
  wire st_lall = (mode_status_r == CMC_LISTEN_ALL);
  wire st_lonly = (mode_status_r == CMC_LISTEN_ONLY);
  wire st_dis = (mode_status_r == CMC_DISABLE);
  wire tx_mode = st_normal || is_loop;
  wire rx_mode = st_normal || st_lall || st_lonly;
  wire own_tx = st_normal || st_lall;
  wire halted = stop_in_idle_r && dev_idle;
  wire run = !halted && !offline;

  // transmit request and abort
  wire dis_abort = tx_wait_r && wr_c1 && (wreq == CMC_DISABLE) &&
                   (|tx_request_flag_r);
  wire abort_now = abort_all_tx_r || dis_abort;
  wire abort_all_tx_done = abort_all_tx_r && (tx_request_flag_r == 8'h00) &&
                   !eng_tx_busy;
  wire [7:0] txc_set = wr_txc ? pwdata[7:0] : 8'h00;
  wire [7:0] txa_clr = wr_txc ? pwdata[`CMC_F_TX_ABORTED_FLAG +: 8] : 8'h00;
  wire [7:0] tx_request_nxt = abort_now ? 8'h00 :
    ((tx_request_flag_r & ~eng_tx_done) | txc_set);
  // set wins over a simultaneous clear
  wire [7:0] tx_aborted_nxt = (tx_aborted_flag_r & ~txa_clr) |
    (abort_now ? tx_request_flag_r : 8'h00);
  wire abort_all_nxt = wr_c1 ? pwdata[`CMC_F_ABORT_ALL_TX] :
                       (abort_all_tx_done ? 1'b0 : abort_all_tx_r);
  wire tx_wait_nxt = change_ok ? new_tx_mode :
                     ((idle_ok || !tx_mode) ? 1'b0 : tx_wait_r);

  // wake detection with optional low-pass filter
  wire sleeping = dev_sleep || st_dis;
  wire [7:0] wcnt_nxt = rx_s ? 8'h00 :
    ((wcnt_r == 8'hFF) ? wcnt_r : wcnt_r + 8'h01);
  wire wake_lo = wake_filter_select_r ?
    (wcnt_r >= 8'(WAKE_CYC)) : !rx_s;
  wire wake_evt = sleeping && wake_lo && !wake_lo_r;
  wire wake_nxt = (bus_wake_flag_r &
    ~(wr_txc & pwdata[`CMC_F_WAKE])) | wake_evt;

  // configuration field writes and engine filter hits, illegal codes are dropped
  wire nfc_ok = (pwdata[4:0] <= `CMC_NFC_MAX);
  wire dma_buffer_count_ok = (pwdata[`CMC_F_DMA_BUFFER_COUNT +: 3] != 3'h7);
  wire hit_ok = (eng_filter_hit <= `CMC_HIT_MAX);

  // apb slave response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_acc;
      pslverr <= setup_acc & ~hit_any;
      if (setup_acc && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // control register one and mode state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_in_idle_r <= 1'b0;
      mode_request_r <= `CMC_RST_MODE;
      rx_capture_link_en_r <= 1'b0;
      register_window_select_r <= 1'b0;
    end else if (wr_c1) begin
      stop_in_idle_r <= pwdata[`CMC_F_STOP_IN_IDLE];
      mode_request_r <= wreq;
      rx_capture_link_en_r <= pwdata[`CMC_F_CAP];
      register_window_select_r <= pwdata[`CMC_F_WIN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_status_r <= CMC_CONFIG;
      tx_wait_r <= 1'b0;
      abort_all_tx_r <= 1'b0;
    end else begin
      if (change_ok) begin
        mode_status_r <= cmc_mode_t'(new_mode);
      end
      tx_wait_r <= tx_wait_nxt;
      abort_all_tx_r <= abort_all_nxt;
    end
  end

  // transmit flags and wake flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_request_flag_r <= 8'h00;
      tx_aborted_flag_r <= 8'h00;
      bus_wake_flag_r <= 1'b0;
      wake_filter_select_r <= 1'b0;
      wake_lo_r <= 1'b0;
      wcnt_r <= 8'h00;
    end else begin
      tx_request_flag_r <= tx_request_nxt;
      tx_aborted_flag_r <= tx_aborted_nxt;
      bus_wake_flag_r <= wake_nxt;
      wake_lo_r <= wake_lo;
      wcnt_r <= wcnt_nxt;
      if (wr_txc) begin
        wake_filter_select_r <= pwdata[`CMC_F_WFIL];
      end
    end
  end

  // locked configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_filter_bit_count_r <= 5'h00;
      dma_buffer_count_r <= 3'h0;
      fifo_start_buffer_r <= 5'h00;
    end else begin
      if (wr_c2 && nfc_ok) begin
        net_filter_bit_count_r <= pwdata[4:0];
      end
      if (wr_fc && dma_buffer_count_ok) begin
        dma_buffer_count_r <= pwdata[`CMC_F_DMA_BUFFER_COUNT +: 3];
      end
      if (wr_fc) begin
        fifo_start_buffer_r <= pwdata[4:0];
      end
    end
  end

  // status captured from the protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_hit_number_r <= 5'h00;
      interrupt_code_r <= `CMC_RST_INTERRUPT_CODE;
      fifo_write_pointer_r <= 6'h00;
      fifo_next_read_pointer_r <= 6'h00;
    end else begin
      if (eng_vec_we) begin
        interrupt_code_r <= eng_interrupt_code;
      end
      if (eng_vec_we && hit_ok) begin
        filter_hit_number_r <= eng_filter_hit;
      end
      fifo_write_pointer_r <= eng_fifo_wr;
      fifo_next_read_pointer_r <= eng_fifo_rd;
    end
  end

  // engine and pin controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_transmit_line <= 1'b1;
      bus_transmit_oe_n <= 1'b1;
      bus_pins_owned <= 1'b0;
      eng_rx_bit <= 1'b1;
      eng_enable <= 1'b0;
      tx_go <= 8'h00;
      tx_abort <= 1'b0;
    end else begin
      bus_transmit_line <= own_tx ? eng_tx_bit : 1'b1;
      bus_transmit_oe_n <= !own_tx;
      bus_pins_owned <= rx_mode;
      eng_rx_bit <= is_loop ? eng_tx_bit :
                    (rx_mode ? rx_s : 1'b1);
      eng_enable <= run;
      tx_go <= (tx_mode && run && !tx_wait_r && !abort_now) ?
               tx_request_flag_r : 8'h00;
      tx_abort <= abort_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ignore <= 1'b0;
      listen_passive <= 1'b0;
      err_cnt_clear <= 1'b1;
      err_cnt_hold <= 1'b0;
      cap_event <= 1'b0;
      wake_filter_on <= 1'b0;
      filter_window <= 1'b0;
      net_filter_bits <= 5'h00;
      dma_buf_total <= 6'h04;
      fifo_start <= 5'h00;
    end else begin
      err_ignore <= st_lall;
      listen_passive <= st_lonly;
      err_cnt_clear <= is_cfg;
      err_cnt_hold <= st_dis || st_lonly;
      cap_event <= rx_capture_link_en_r && eng_rx_msg && run;
      wake_filter_on <= sleeping && wake_filter_select_r;
      filter_window <= register_window_select_r;
      net_filter_bits <= net_filter_bit_count_r;
      dma_buf_total <= cmc_buf_total(dma_buffer_count_r);
      fifo_start <= fifo_start_buffer_r;
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wait_dis;
    tx_wait_r && wr_c1 && wreq == CMC_DISABLE && |tx_request_flag_r;
  endsequence

  sequence s_abort_seen;
    tx_request_flag_r == 8'h00 && tx_aborted_flag_r != 8'h00;
  endsequence

  a_rsvd_hold:
    assert property (!req_legal |=> $stable(mode_status_r))
    else $error("reserved request changed the mode");

  a_mode_idle:
    assert property ($changed(mode_status_r) |->
      $past(offline) || ($past(idle_ok) && !$past(eng_tx_busy)))
    else $error("mode changed while bus busy");

  a_dis_pins:
    assert property (st_dis |=> bus_transmit_oe_n && !bus_pins_owned)
    else $error("disable mode still owns bus pins");

  a_normal_owns:
    assert property (st_normal |=> !bus_transmit_oe_n && bus_pins_owned)
    else $error("normal mode does not own bus pins");

  a_loop_route:
    assert property (is_loop |=>
      eng_rx_bit == $past(eng_tx_bit) && bus_transmit_oe_n)
    else $error("loopback path broken");

  a_wait_gate:
    assert property (tx_wait_r |=> tx_go == 8'h00)
    else $error("transmit started inside idle wait");

  a_dis_abort:
    assert property (s_wait_dis |=> s_abort_seen)
    else $error("disable during wait did not abort");

  a_abort_all_tx_clear:
    assert property (abort_all_tx_done && !wr_c1 |=> !abort_all_tx_r ##1
      !abort_all_tx_r || $past(wr_c1))
    else $error("abort-all bit not cleared");

  a_listen_only:
    assert property (st_lonly |=>
      bus_transmit_oe_n && listen_passive && err_cnt_hold)
    else $error("listen-only mode not passive");

  a_cap_gate:
    assert property (!rx_capture_link_en_r |=> !cap_event)
    else $error("capture event while link disabled");

  a_wake_set:
    assert property (wake_evt |=> bus_wake_flag_r)
    else $error("wake event lost");

  a_nfc_range:
    assert property (net_filter_bit_count_r <= `CMC_NFC_MAX)
    else $error("invalid network filter bit count held");

  a_cfg_clear:
    assert property (is_cfg |=> err_cnt_clear && !eng_enable)
    else $error("configuration mode not quiet");

endmodule

// ---- hw/cmc_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB, one aligned word per register
// Notes: definitions only
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

`define CMC_OFS_CTRL1 8'h00
`define CMC_OFS_CTRL2 8'h04
`define CMC_OFS_VEC 8'h08
`define CMC_OFS_FCTRL 8'h0C
`define CMC_OFS_FPTR 8'h10
`define CMC_OFS_TXC 8'h14

`define CMC_F_STOP_IN_IDLE 13
`define CMC_F_ABORT_ALL_TX 12
`define CMC_F_REQ 8
`define CMC_F_CAP 3
`define CMC_F_WIN 0
`define CMC_F_DMA_BUFFER_COUNT 13
`define CMC_F_TX_ABORTED_FLAG 8
`define CMC_F_WAKE 16
`define CMC_F_WFIL 17

`define CMC_RST_MODE 3'h4
`define CMC_RST_INTERRUPT_CODE 7'h40
`define CMC_NFC_MAX 5'h11
`define CMC_HIT_MAX 5'h0F
`define CMC_IDLE_BITS 4'hB

`define CMC_CLK_NS 10
`define CMC_BIT_NS 1000
`define CMC_BIT_CYC ((`CMC_BIT_NS) / (`CMC_CLK_NS))
`define CMC_WAKE_NS 500
`define CMC_WAKE_CYC ((`CMC_WAKE_NS) / (`CMC_CLK_NS))

`endif

// ---- hw/cmc_pkg.sv ----
// Purpose: shared types of the CAN mode control block
// Assumes: nothing
// Notes: mode codes follow the request/status field encoding
package cmc_pkg;

  typedef enum logic [2:0] {
    CMC_NORMAL = 3'h0,
    CMC_DISABLE = 3'h1,
    CMC_LOOPBACK = 3'h2,
    CMC_LISTEN_ONLY = 3'h3,
    CMC_CONFIG = 3'h4,
    CMC_RSVD5 = 3'h5,
    CMC_RSVD6 = 3'h6,
    CMC_LISTEN_ALL = 3'h7
  } cmc_mode_t;

  // number of message buffers in the shared memory area
  function automatic logic [5:0] cmc_buf_total(input logic [2:0] code);
    logic [5:0] n;
    n = 6'h04;
    unique case (code)
      3'h0: n = 6'h04;
      3'h1: n = 6'h06;
      3'h2: n = 6'h08;
      3'h3: n = 6'h0C;
      3'h4: n = 6'h10;
      3'h5: n = 6'h18;
      3'h6: n = 6'h20;
      3'h7: n = 6'h04;
    endcase
    return n;
  endfunction

endpackage

// ---- hw/cmc_sync.sv ----
// Purpose: three-stage synchroniser for an asynchronous pin
// Assumes: input may change at any time
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps

module cmc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule

// ---- hw/cmc_bus_idle.sv ----
// Purpose: bus idle detector, counts consecutive recessive bits
// Assumes: rx is synchronised; bit rate from a clock divider
// Notes: restart clears the count and realigns the bit divider
`timescale 1ns/1ps
`include "cmc_map.svh"

module cmc_bus_idle #(
  parameter int BIT_CYC = `CMC_BIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic rx,
  output logic idle_ok
);
  localparam int DW = $clog2(BIT_CYC + 1);
  logic [DW-1:0] div_r;
  logic [3:0] bits_r;
  wire tick = (div_r == DW'(BIT_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
      bits_r <= 4'h0;
      idle_ok <= 1'b0;
    end else if (restart) begin
      div_r <= '0;
      bits_r <= 4'h0;
      idle_ok <= 1'b0;
    end else begin
      div_r <= tick ? '0 : div_r + 1'b1;
      if (!rx) begin
        // any dominant level breaks the idle run
        bits_r <= 4'h0;
        idle_ok <= 1'b0;
      end else if (tick && bits_r != `CMC_IDLE_BITS) begin
        bits_r <= bits_r + 4'h1;
        idle_ok <= (bits_r == `CMC_IDLE_BITS - 4'h1);
      end
    end
  end
endmodule

// ---- test/cmc_bus_node.sv ----
// Purpose: far-side CAN node sharing the bus with the device
// Assumes: bit time of BIT pclk cycles; line idles recessive
// Notes: busy sends a dominant bit every fifth bit, never 11 recessive
`timescale 1ns/1ps

module cmc_bus_node #(
  parameter int BIT = 4
) (
  input wire logic pclk,
  input wire logic busy,
  input wire logic tx,
  input wire logic tx_oe_n,
  output logic rx
);
  int cyc = 0;
  int nbit = 0;
  logic own = 1'b1;
  always @(posedge pclk) begin
    cyc <= (cyc == BIT - 1) ? 0 : cyc + 1;
    if (cyc == BIT - 1) begin
      nbit <= (nbit == 4) ? 0 : nbit + 1;
      own <= !(busy && nbit == 4);
    end
  end
  // wired-and: a dominant bit from either node wins
  assign rx = own & (tx_oe_n | tx);
endmodule

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the CAN mode control block
// Assumes: APB answers with one wait state; bit time of 4 cycles
// Notes: reads queue their expected word, a monitor compares them
`timescale 1ns/1ps
`include "cmc_map.svh"

module testbench;
  import cmc_pkg::*;
  localparam int BIT = 4;
  localparam int IDLE = 11 * BIT + 12;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx, txl, oe_n, owned, rxb, ign, pas, clr, hold;
  logic register_window_select, busy = 1'b0, tx_bit = 1'b1, vec_we = 1'b0;
  logic dvi = 1'b0, slp = 1'b0, rxm = 1'b0, en, cap, wfo;
  logic [7:0] tx_go;
  logic [4:0] nfb, fs, hit = 5'h00;
  logic [6:0] interrupt_code = 7'h00;
  logic [5:0] dma, fwr = 6'h00, frd = 6'h00;
  logic [5:0] sizes [7] = '{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20};
  logic [32:0] expq [$];
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'h8CCB956A;

  cmc_top #(.BIT_CYC(BIT), .WAKE_CYC(3)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_receive_line(rx),
    .bus_transmit_line(txl), .bus_transmit_oe_n(oe_n),
    .bus_pins_owned(owned), .dev_idle(dvi), .dev_sleep(slp),
    .eng_tx_bit(tx_bit), .eng_tx_busy(1'b0), .eng_tx_done(8'h00),
    .eng_rx_msg(rxm), .eng_vec_we(vec_we), .eng_filter_hit(hit),
    .eng_interrupt_code(interrupt_code), .eng_fifo_wr(fwr), .eng_fifo_rd(frd),
    .eng_rx_bit(rxb), .eng_enable(en), .tx_go(tx_go), .tx_abort(),
    .err_ignore(ign), .listen_passive(pas), .err_cnt_clear(clr),
    .err_cnt_hold(hold), .cap_event(cap), .wake_filter_on(wfo),
    .filter_window(register_window_select), .net_filter_bits(nfb), .dma_buf_total(dma),
    .fifo_start(fs));

  cmc_bus_node #(.BIT(BIT)) u_node (
    .pclk(pclk), .busy(busy), .tx(txl), .tx_oe_n(oe_n), .rx(rx));

  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk({pslverr, prdata}, expq.size() > 0 ? expq.pop_front() : 33'bx);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    repeat (2) @(posedge pclk);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic st();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  initial begin
    logic [4:0] f, h;
    logic [6:0] c;
    logic [5:0] w6, r6;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CMC_OFS_CTRL1, 33'h480);
    rd(`CMC_OFS_VEC, 33'h40);
    rd(8'h20, {1'b1, 32'h0});
    chk(33'(clr), 33'h1);
    chk(33'({owned, oe_n}), 33'h1);
    wr(`CMC_OFS_CTRL1, 32'h401);
    st();
    chk(33'(register_window_select), 33'h1);
    wr(`CMC_OFS_CTRL1, 32'h400);
    st();
    chk(33'(register_window_select), 33'h0);
    wr(`CMC_OFS_CTRL2, 32'h11);
    wr(`CMC_OFS_CTRL2, 32'h12);
    rd(`CMC_OFS_CTRL2, 33'h11);
    st();
    chk(33'(nfb), 33'h11);
    for (int i = 0; i < 8; i++) begin
      f = 5'($random(seed));
      wr(`CMC_OFS_FCTRL, {16'h0, i[2:0], 8'h0, f});
      st();
      chk(33'({dma, fs}), 33'({sizes[i < 7 ? i : 6], f}));
      if (i < 7) rd(`CMC_OFS_FCTRL, {17'h0, i[2:0], 8'h0, f});
    end
    h = 5'($random(seed)) & 5'h0F;
    c = 7'($random(seed));
    hit <= h;
    interrupt_code <= c;
    vec_we <= 1'b1;
    @(posedge pclk);
    vec_we <= 1'b0;
    rd(`CMC_OFS_VEC, {20'h0, h, 1'b0, c});
    hit <= 5'h10;
    interrupt_code <= 7'h41;
    vec_we <= 1'b1;
    @(posedge pclk);
    vec_we <= 1'b0;
    rd(`CMC_OFS_VEC, {20'h0, h, 1'b0, 7'h41});
    w6 = 6'($random(seed)) & 6'h1F;
    r6 = 6'($random(seed)) & 6'h1F;
    fwr <= w6;
    frd <= r6;
    rd(`CMC_OFS_FPTR, {19'h0, w6, 2'b0, r6});
    busy <= 1'b1;
    wr(`CMC_OFS_CTRL1, 32'h0);
    rd(`CMC_OFS_CTRL1, 33'h0);
    st();
    chk(33'({owned, oe_n}), 33'h2);
    wr(`CMC_OFS_CTRL1, 32'h500);
    rd(`CMC_OFS_CTRL1, 33'h500);
    wr(`CMC_OFS_CTRL1, 32'h100);
    repeat (IDLE) @(posedge pclk);
    rd(`CMC_OFS_CTRL1, 33'h100);
    busy <= 1'b0;
    repeat (IDLE) @(posedge pclk);
    rd(`CMC_OFS_CTRL1, 33'h120);
    st();
    chk(33'({owned, oe_n}), 33'h1);
    chk(33'(hold), 33'h1);
    wr(`CMC_OFS_CTRL1, 32'h200);
    rd(`CMC_OFS_CTRL1, 33'h240);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      tx_bit <= 1'($random(seed));
      st();
      chk(33'(rxb), 33'(tx_bit));
    end
    @(posedge pclk);
    tx_bit <= 1'b1;
    chk(33'({owned, oe_n}), 33'h1);
    wr(`CMC_OFS_CTRL1, 32'h700);
    repeat (IDLE) @(posedge pclk);
    rd(`CMC_OFS_CTRL1, 33'h7E0);
    st();
    chk(33'({ign, oe_n}), 33'h2);
    wr(`CMC_OFS_CTRL1, 32'h300);
    repeat (IDLE) @(posedge pclk);
    rd(`CMC_OFS_CTRL1, 33'h360);
    st();
    chk(33'({pas, owned, oe_n}), 33'h7);
    wr(`CMC_OFS_CTRL1, 32'h2308);
    @(posedge pclk);
    rxm <= 1'b1;
    @(posedge pclk);
    rxm <= 1'b0;
    dvi <= 1'b1;
    #1;
    chk(33'({cap, en}), 33'h3);
    @(posedge pclk);
    #1;
    chk(33'({cap, en}), 33'h0);
    @(posedge pclk);
    dvi <= 1'b0;
    wr(`CMC_OFS_TXC, 32'h0F);
    wr(`CMC_OFS_CTRL1, 32'h1300);
    rd(`CMC_OFS_TXC, 33'hF00);
    rd(`CMC_OFS_CTRL1, 33'h360);
    wr(`CMC_OFS_TXC, 32'h20000);
    slp <= 1'b1;
    busy <= 1'b1;
    repeat (IDLE) @(posedge pclk);
    chk(33'(wfo), 33'h1);
    slp <= 1'b0;
    busy <= 1'b0;
    rd(`CMC_OFS_TXC, 33'h30F00);
    wr(`CMC_OFS_CTRL1, 32'h400);
    repeat (IDLE) @(posedge pclk);
    rd(`CMC_OFS_CTRL1, 33'h480);
    wr(`CMC_OFS_TXC, 32'h10F03);
    wr(`CMC_OFS_CTRL1, 32'h0);
    st();
    chk(33'(tx_go), 33'h0);
    wr(`CMC_OFS_CTRL1, 32'h100);
    rd(`CMC_OFS_TXC, 33'h300);
    end_sim();
  end
endmodule
